// file: verif/flash_device_model.sv
`timescale 1ns/1ps
// ===========================================================
// behavioural flash device driven by its strobes
module flash_device_model (
  // flash pins
  input wire logic [15:0] i_dq,
  input wire logic i_ce_b,
  input wire logic i_oe_b,
  input wire logic i_we_b,
  input wire logic i_reset_b,
  output logic [15:0] o_dq
);
  logic [15:0] word_reg = 16'hFFFF;
  logic [7:0] prev_reg = 8'h00;
  logic toggle_reg = 1'b0, timer_reg = 1'b0, chip_reg = 1'b0;
  logic susp_reg = 1'b0;
  int busy = 0;
  // commands land on the rising write strobe; chip erase deaf to all
  always @(posedge i_we_b or negedge i_reset_b) begin
    if (!i_reset_b) begin
      busy = 0;
      susp_reg = 1'b0;
    end else if (!i_ce_b && !(chip_reg && busy > 0)) begin
      chip_reg = 1'b0;
      case (i_dq[7:0])
        8'h10: begin
          busy = 6;
          chip_reg = 1'b1;
        end
        8'h30: begin
          busy = 6;
          timer_reg = 1'b0;
          susp_reg = 1'b0;
        end
        8'hB0: if (busy > 0) susp_reg = 1'b1;
        8'hF0: if (!susp_reg) busy = 0;
        8'h29: if (prev_reg == 8'h76) busy = 6;
        default: ;
      endcase
      if (susp_reg) busy = 0;
      prev_reg = i_dq[7:0];
    end
  end
  // each read while busy gives status and flips the toggle bit
  always @(negedge i_oe_b) begin
    if (busy > 0) begin
      word_reg = {9'h000, toggle_reg, 2'b00, timer_reg, 3'b000};
      toggle_reg = ~toggle_reg;
      timer_reg = 1'b1;
      busy = busy - 1;
    end else word_reg = 16'hFFFF;
  end
  // a released bus shows the inverse so stale data cannot pass
  assign o_dq = (!i_oe_b && !i_ce_b) ? word_reg : ~word_reg;
endmodule

// file: verif/flash_host_assertions.sv
`timescale 1ns/1ps
// ===========================================================
// pin and apb checks for the flash host
module flash_host_checker (
  // clock, reset and apb
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // flash pins
  input wire logic [22:0] o_flash_addr,
  input wire logic o_flash_dq_oe_b,
  input wire logic o_flash_ce_b,
  input wire logic o_flash_oe_b,
  input wire logic o_flash_we_b,
  input wire logic o_flash_reset_b
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // write strobe low five clocks, chip select kept three more
  sequence s_we_low; !o_flash_we_b [*5] ##1 o_flash_we_b; endsequence
  sequence s_ce_hold; !o_flash_ce_b [*3] ##1 o_flash_ce_b; endsequence
  property p_we_pulse; $fell(o_flash_we_b) |-> s_we_low; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we width");
  property p_ce_hold; $rose(o_flash_we_b) |-> s_ce_hold; endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("ce hold");
  property p_drive; !o_flash_we_b |-> !o_flash_dq_oe_b && !o_flash_ce_b;
  endproperty
  a_drive: assert property (p_drive) else $error("write undriven");
  property p_listen; !o_flash_oe_b |-> o_flash_dq_oe_b && o_flash_we_b;
  endproperty
  a_listen: assert property (p_listen) else $error("read clash");
  property p_addr; !o_flash_ce_b && $past(!o_flash_ce_b) |->
    $stable(o_flash_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_ready; i_psel && i_penable |-> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_slverr; o_pslverr |-> i_psel && i_penable; endproperty
  a_slverr: assert property (p_slverr) else $error("stray error");
  property p_hw; $fell(o_flash_reset_b) |-> !o_flash_reset_b [*8];
  endproperty
  a_hw: assert property (p_hw) else $error("reset pulse short");
  property p_quiet; !o_flash_reset_b |-> o_flash_ce_b && o_flash_we_b;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus in reset");
endmodule
bind flash_host flash_host_checker i_checker (.i_clock, .i_rst_b,
  .i_psel, .i_penable, .o_pready, .o_pslverr, .o_flash_addr,
  .o_flash_dq_oe_b, .o_flash_ce_b, .o_flash_oe_b, .o_flash_we_b,
  .o_flash_reset_b);

// file: verif/test_flash_host.sv
`timescale 1ns/1ps
// ===========================================================
// apb bench for the flash host
module test_flash_host;
  logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, dq_oe_b, ce_b, oe_b, we_b, fr_b;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [22:0] fl_addr;
  logic [15:0] dq_out, dev_dq, dq_wire;
  logic [32:0] rd;
  logic [47:0] codes = 48'h0;
  int errors = 0, samples_checked = 0, cycles = 0;
  // wire level: the host wins while its enable is low
  assign dq_wire = dq_oe_b ? dev_dq : dq_out;
  flash_host i_dut (.i_clock(clock), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_flash_addr(fl_addr), .o_flash_dq_out(dq_out),
    .o_flash_dq_oe_b(dq_oe_b), .i_flash_dq_in(dq_wire),
    .o_flash_ce_b(ce_b), .o_flash_oe_b(oe_b), .o_flash_we_b(we_b),
    .o_flash_reset_b(fr_b));
  flash_device_model i_flash (.i_dq(dq_wire), .i_ce_b(ce_b),
    .i_oe_b(oe_b), .i_we_b(we_b), .i_reset_b(fr_b), .o_dq(dev_dq));
  // clock, code trail of flash writes, and hang guard
  initial forever #5 clock = ~clock;
  always @(posedge we_b) codes = {codes[39:0], dq_wire[7:0]};
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      errors++;
      finish_test();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // order an operation and read status until it is no longer busy
  task automatic run(input logic [3:0] op);
    apb(flash_host_pkg::REG_CMD, 1'b1, {28'h0, op});
    apb(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
    while (rd[flash_host_pkg::ST_BUSY] !== 1'b0)
      apb(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
  endtask
  // clear sticky bits, then poll the device until it reports done
  task automatic settle();
    apb(flash_host_pkg::REG_STATUS, 1'b1, 32'h0000001E);
    rd = 33'h0;
    while (rd[flash_host_pkg::ST_DONE] !== 1'b1) run(flash_host_pkg::OP_POLL);
  endtask
  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    apb(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
    check(rd, 33'h0);
    apb(12'h014, 1'b0, 32'h0);
    check(rd[32], 1'b1);
    run(flash_host_pkg::OP_CHIP);
    check(codes, 48'hAA5580AA5510);
    run(flash_host_pkg::OP_SUSPEND);
    check(rd[3], 1'b1);
    settle();
    check(rd[11], 1'b0);
    run(flash_host_pkg::OP_BLANK);
    check(codes[23:0], 24'hEB7629);
    settle();
    check(rd[12], 1'b0);
    apb(flash_host_pkg::REG_ADDR, 1'b1, 32'h00010000);
    run(flash_host_pkg::OP_SECTOR);
    check(codes, 48'hAA5580AA5530);
    check(fl_addr, 23'h010000);
    run(flash_host_pkg::OP_ADD);
    check(codes[15:0], 16'h3030);
    run(flash_host_pkg::OP_SUSPEND);
    check(rd[10], 1'b1);
    run(flash_host_pkg::OP_RESUME);
    check(codes[23:0], 24'hB0F030);
    run(flash_host_pkg::OP_HWRESET);
    check(rd[4], 1'b1);
    run(flash_host_pkg::OP_ADD);
    check(rd[3], 1'b1);
    // program, suspend, resume twice: the second resume must bounce
    apb(flash_host_pkg::REG_STATUS, 1'b1, 32'h00000008);
    apb(flash_host_pkg::REG_WDATA, 1'b1, 32'h00001234);
    run(flash_host_pkg::OP_PROGRAM);
    run(flash_host_pkg::OP_SUSPEND);
    check(rd[8], 1'b1);
    run(flash_host_pkg::OP_RESUME);
    run(flash_host_pkg::OP_RESUME);
    check(rd[3], 1'b1);
    check(rd[8:7], 2'b01);
    check(codes[39:0], 40'hA034B0F030);
    finish_test();
  end
endmodule

// file: verilog/flash_bus_cycle.sv
`timescale 1ns/1ps
// ===========================================================
// one asynchronous write or read cycle on the flash pins
module flash_bus_cycle (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_done,
  output logic [15:0] o_rdata,
  // flash pins
  input wire logic [15:0] i_dq_in,
  output logic [22:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe_b,
  output logic o_ce_b,
  output logic o_oe_b,
  output logic o_we_b
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_SETUP = 2'b01, C_STROBE = 2'b10, C_HOLD = 2'b11
  } cyc_state_type;
  cyc_state_type state_reg;
  logic [7:0] cnt_reg;
  logic write_reg;
  wire logic cnt_zero = (cnt_reg == 8'h00);
  // pins all come from flops so no glitch reaches the device
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      write_reg <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_addr <= 23'h000000;
      o_dq_out <= 16'h0000;
      o_dq_oe_b <= 1'b1;
      o_ce_b <= 1'b1;
      o_oe_b <= 1'b1;
      o_we_b <= 1'b1;
    end else begin
      o_done <= 1'b0;
      if (!cnt_zero) cnt_reg <= cnt_reg - 8'h01;
      unique case (state_reg)
        C_IDLE: if (i_start) begin
          write_reg <= i_write;
          o_addr <= i_addr;
          o_dq_out <= i_wdata;
          o_dq_oe_b <= !i_write;
          o_ce_b <= 1'b0;
          cnt_reg <= 8'(flash_host_pkg::CYC_SETUP - 1);
          state_reg <= C_SETUP;
        end
        C_SETUP: if (cnt_zero) begin
          o_we_b <= !write_reg;
          o_oe_b <= write_reg;
          cnt_reg <= write_reg ? 8'(flash_host_pkg::CYC_WE - 1)
            : 8'(flash_host_pkg::CYC_ACCESS - 1);
          state_reg <= C_STROBE;
        end
        C_STROBE: if (cnt_zero) begin
          if (!write_reg) o_rdata <= i_dq_in;
          o_we_b <= 1'b1;
          o_oe_b <= 1'b1;
          cnt_reg <= 8'(flash_host_pkg::CYC_HOLD - 1);
          state_reg <= C_HOLD;
        end
        C_HOLD: if (cnt_zero) begin
          o_ce_b <= 1'b1;
          o_dq_oe_b <= 1'b1;
          o_done <= 1'b1;
          state_reg <= C_IDLE;
        end
      endcase
    end
  end
endmodule

// file: verilog/flash_host.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// ===========================================================
// Operation
// - resume code ends program suspend
// - chip erase is six writes ending 10h
// - hardware reset cuts erase; reissue it
// - sector erase: unlocks, setup, unlocks, 30h
// - after error issue read/reset
// - leave side modes with reset before resume
// - resume code from read mode, repeatable; host refuses a second resume
// - blank check setup then confirm, error cleared
module flash_host (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // flash pins
  output logic [22:0] o_flash_addr,
  output logic [15:0] o_flash_dq_out,
  output logic o_flash_dq_oe_b,
  input wire logic [15:0] i_flash_dq_in,
  output logic o_flash_ce_b,
  output logic o_flash_oe_b,
  output logic o_flash_we_b,
  output logic o_flash_reset_b
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_CYCLE = 2'b01, M_RST_LOW = 2'b10,
    M_RST_WAIT = 2'b11
  } main_state_type;
  main_state_type state_reg;
  flash_host_pkg::op_type op_reg;
  logic [2:0] step_reg;
  logic issue_reg;
  logic [11:0] wait_reg;
  logic [22:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] first_reg;
  logic [15:0] rdata_reg;
  logic done_reg, error_reg, refused_reg, cut_reg, timer_reg;
  logic window_reg, prog_run_reg, prog_susp_reg;
  logic sect_run_reg, sect_susp_reg, chip_run_reg, blank_run_reg;
  logic [31:0] prdata_reg;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic poll_done, poll_error, poll_timer;
  logic op_ok;
  logic [20:0] seq;

  // ===========================================================
  // apb decode, zero wait state
  wire logic hit = i_paddr == flash_host_pkg::REG_CMD
    || i_paddr == flash_host_pkg::REG_ADDR
    || i_paddr == flash_host_pkg::REG_WDATA
    || i_paddr == flash_host_pkg::REG_STATUS
    || i_paddr == flash_host_pkg::REG_RDATA;
  wire logic access = i_psel && i_penable;
  wire logic wr = access && i_pwrite && hit;
  wire logic wr_cmd = wr && i_paddr == flash_host_pkg::REG_CMD;
  wire logic wr_stat = wr && i_paddr == flash_host_pkg::REG_STATUS;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;
  assign o_prdata = prdata_reg;

  wire logic [3:0] cmd_code = i_pwdata[3:0];
  wire flash_host_pkg::op_type cmd_op = flash_host_pkg::op_type'(cmd_code);
  wire logic cmd_known = cmd_code <= 4'hA;
  wire logic busy = state_reg != M_IDLE;
  wire logic locked = chip_run_reg || blank_run_reg;
  wire logic dev_quiet = !(locked || window_reg || prog_run_reg
    || prog_susp_reg || sect_run_reg || sect_susp_reg);
  wire logic start = wr_cmd && !busy && cmd_known && op_ok;
  wire logic refuse = wr_cmd && !start;

  // which orders the device can take in its present mode
  always_comb begin
    op_ok = 1'b0;
    unique case (cmd_op)
      flash_host_pkg::OP_POLL, flash_host_pkg::OP_HWRESET: op_ok = 1'b1;
      flash_host_pkg::OP_ADD: op_ok = window_reg;
      flash_host_pkg::OP_SUSPEND:
        op_ok = (prog_run_reg || sect_run_reg) && !locked;
      flash_host_pkg::OP_RESUME:
        op_ok = (prog_susp_reg || sect_susp_reg) && !prog_run_reg
          && !locked;
      flash_host_pkg::OP_READ, flash_host_pkg::OP_RESET:
        op_ok = !locked && !prog_run_reg && !window_reg;
      flash_host_pkg::OP_PROGRAM:
        op_ok = !locked && !prog_run_reg && !window_reg
          && !sect_run_reg;
      flash_host_pkg::OP_CHIP, flash_host_pkg::OP_SECTOR,
        flash_host_pkg::OP_BLANK: op_ok = dev_quiet;
      default: op_ok = 1'b0;
    endcase
  end

  // ===========================================================
  // command sequence table
  // word: write, last, address select (0 unlock1, 1 unlock2,
  // 2 target), use write data, code
  function automatic logic [20:0] seq_step(
    input flash_host_pkg::op_type op, input logic [2:0] step);
    logic [20:0] w;
    w = {1'b1, 1'b1, 2'd2, 1'b0, flash_host_pkg::CODE_READ_RESET};
    unique case (op)
      flash_host_pkg::OP_READ: w = {1'b0, 1'b1, 2'd2, 1'b0, 16'h0000};
      flash_host_pkg::OP_POLL:
        w = {1'b0, step == 3'd1, 2'd2, 1'b0, 16'h0000};
      flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP,
      flash_host_pkg::OP_SECTOR: begin
        unique case (step)
          3'd0, 3'd3:
            w = {1'b1, 1'b0, 2'd0, 1'b0, flash_host_pkg::CODE_UNLOCK_1};
          3'd1, 3'd4:
            w = {1'b1, 1'b0, 2'd1, 1'b0, flash_host_pkg::CODE_UNLOCK_2};
          3'd2: w = (op == flash_host_pkg::OP_PROGRAM)
            ? {1'b1, 1'b0, 2'd0, 1'b0, flash_host_pkg::CODE_PROGRAM}
            : {1'b1, 1'b0, 2'd0, 1'b0, flash_host_pkg::CODE_ERASE_SETUP};
          default: w = (op == flash_host_pkg::OP_CHIP)
            ? {1'b1, 1'b1, 2'd0, 1'b0,
               flash_host_pkg::CODE_CHIP_ERASE}
            : {1'b1, 1'b1, 2'd2, 1'b0,
               flash_host_pkg::CODE_SECTOR_ERASE};
        endcase
        if (op == flash_host_pkg::OP_PROGRAM && step == 3'd3)
          w = {1'b1, 1'b1, 2'd2, 1'b1, 16'h0000};
      end
      flash_host_pkg::OP_ADD:
        w = {1'b1, 1'b1, 2'd2, 1'b0, flash_host_pkg::CODE_SECTOR_ERASE};
      flash_host_pkg::OP_SUSPEND:
        w = {1'b1, 1'b1, 2'd2, 1'b0, flash_host_pkg::CODE_SUSPEND};
      flash_host_pkg::OP_RESUME:
        w = (step == 3'd0)
          ? {1'b1, 1'b0, 2'd2, 1'b0, flash_host_pkg::CODE_READ_RESET}
          : {1'b1, 1'b1, 2'd2, 1'b0, flash_host_pkg::CODE_RESUME};
      flash_host_pkg::OP_BLANK: begin
        unique case (step)
          3'd0: w = {1'b1, 1'b0, 2'd2, 1'b0,
            flash_host_pkg::CODE_BLANK_SETUP_1};
          3'd1: w = {1'b1, 1'b0, 2'd2, 1'b0,
            flash_host_pkg::CODE_BLANK_SETUP_2};
          default: w = {1'b1, 1'b1, 2'd2, 1'b0,
            flash_host_pkg::CODE_BLANK_CONFIRM};
        endcase
      end
      default: w = {1'b1, 1'b1, 2'd2, 1'b0,
        flash_host_pkg::CODE_READ_RESET};
    endcase
    return w;
  endfunction

  assign seq = seq_step(op_reg, step_reg);
  wire logic seq_write = seq[20];
  wire logic seq_last = seq[19];
  wire logic [22:0] seq_addr = (seq[18:17] == 2'd0)
    ? flash_host_pkg::UNLOCK_ADDR_1
    : (seq[18:17] == 2'd1) ? flash_host_pkg::UNLOCK_ADDR_2 : addr_reg;
  wire logic [15:0] seq_data = seq[16] ? wdata_reg : seq[15:0];
  wire logic step_end = state_reg == M_CYCLE && cyc_done;
  wire logic op_end = step_end && seq_last;
  wire logic is_poll = op_reg == flash_host_pkg::OP_POLL;
  wire logic poll_fail = op_end && is_poll && poll_error;

  // ===========================================================
  // pin engine and status judge
  flash_bus_cycle u_cycle (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_start(issue_reg),
    .i_write(seq_write),
    .i_addr(seq_addr),
    .i_wdata(seq_data),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .i_dq_in(i_flash_dq_in),
    .o_addr(o_flash_addr),
    .o_dq_out(o_flash_dq_out),
    .o_dq_oe_b(o_flash_dq_oe_b),
    .o_ce_b(o_flash_ce_b),
    .o_oe_b(o_flash_oe_b),
    .o_we_b(o_flash_we_b)
  );

  flash_status_judge u_judge (
    .i_first(first_reg),
    .i_second(cyc_rdata),
    .o_done(poll_done),
    .o_error(poll_error),
    .o_timer(poll_timer)
  );

  // ===========================================================
  // sequencer: steps, device reset pulse and recovery
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= M_IDLE;
      op_reg <= flash_host_pkg::OP_READ;
      step_reg <= 3'd0;
      issue_reg <= 1'b0;
      wait_reg <= 12'h000;
      o_flash_reset_b <= 1'b1;
    end else begin
      issue_reg <= 1'b0;
      unique case (state_reg)
        M_IDLE: if (start) begin
          op_reg <= cmd_op;
          step_reg <= 3'd0;
          if (cmd_op == flash_host_pkg::OP_HWRESET) begin
            o_flash_reset_b <= 1'b0;
            wait_reg <= 12'(flash_host_pkg::CYC_RST_PULSE - 1);
            state_reg <= M_RST_LOW;
          end else begin
            issue_reg <= 1'b1;
            state_reg <= M_CYCLE;
          end
        end
        M_CYCLE: if (poll_fail) begin
          op_reg <= flash_host_pkg::OP_RESET;
          step_reg <= 3'd0;
          issue_reg <= 1'b1;
        end else if (op_end) begin
          state_reg <= M_IDLE;
        end else if (step_end) begin
          step_reg <= step_reg + 3'd1;
          issue_reg <= 1'b1;
        end
        M_RST_LOW: if (wait_reg == 12'h000) begin
          o_flash_reset_b <= 1'b1;
          wait_reg <= 12'(flash_host_pkg::CYC_RST_RECOVER - 1);
          state_reg <= M_RST_WAIT;
        end else begin
          wait_reg <= wait_reg - 12'h001;
        end
        M_RST_WAIT: if (wait_reg == 12'h000) begin
          state_reg <= M_IDLE;
        end else begin
          wait_reg <= wait_reg - 12'h001;
        end
      endcase
    end
  end

  // ===========================================================
  // software registers and apb read data
  wire logic [31:0] status_word = {first_reg, 3'b000,
    blank_run_reg, chip_run_reg, sect_susp_reg, sect_run_reg,
    prog_susp_reg, prog_run_reg, window_reg, timer_reg, cut_reg,
    refused_reg, error_reg, done_reg, busy};
  wire logic [31:0] rd_mux =
    (i_paddr == flash_host_pkg::REG_CMD) ? {28'h0000000, op_reg}
    : (i_paddr == flash_host_pkg::REG_ADDR) ? {9'h000, addr_reg}
    : (i_paddr == flash_host_pkg::REG_WDATA) ? {16'h0000, wdata_reg}
    : (i_paddr == flash_host_pkg::REG_STATUS) ? status_word
    : (i_paddr == flash_host_pkg::REG_RDATA) ? {16'h0000, rdata_reg}
    : 32'h00000000;

  // read data is caught in the setup cycle so it is a flop
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_reg <= 32'h00000000;
      addr_reg <= flash_host_pkg::ADDR_RESET;
      wdata_reg <= flash_host_pkg::DATA_RESET;
    end else begin
      if (i_psel && !i_penable) prdata_reg <= rd_mux;
      if (wr && i_paddr == flash_host_pkg::REG_ADDR)
        addr_reg <= i_pwdata[22:0];
      if (wr && i_paddr == flash_host_pkg::REG_WDATA)
        wdata_reg <= i_pwdata[15:0];
    end
  end

  // ===========================================================
  // sticky flags: a hardware set beats a write-one clear
  wire logic clr_done = wr_stat && i_pwdata[flash_host_pkg::ST_DONE];
  wire logic clr_err = wr_stat && i_pwdata[flash_host_pkg::ST_ERROR];
  wire logic clr_ref = wr_stat && i_pwdata[flash_host_pkg::ST_REFUSED];
  wire logic clr_cut = wr_stat
    && i_pwdata[flash_host_pkg::ST_ERASE_CUT];
  wire logic hw_start = start && cmd_op == flash_host_pkg::OP_HWRESET;
  wire logic finished = op_end && is_poll && poll_done;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_reg <= 1'b0;
      error_reg <= 1'b0;
      refused_reg <= 1'b0;
      cut_reg <= 1'b0;
    end else begin
      done_reg <= finished || (done_reg && !clr_done);
      error_reg <= poll_fail || (error_reg && !clr_err);
      refused_reg <= refuse || (refused_reg && !clr_ref);
      cut_reg <= (hw_start && (chip_run_reg || sect_run_reg
        || window_reg)) || (cut_reg && !clr_cut);
    end
  end

  // ===========================================================
  // model of the device mode as seen from this side
  wire logic end_prog = op_end && op_reg == flash_host_pkg::OP_PROGRAM;
  wire logic end_chip = op_end && op_reg == flash_host_pkg::OP_CHIP;
  wire logic end_sect = op_end && op_reg == flash_host_pkg::OP_SECTOR;
  wire logic end_blank = op_end && op_reg == flash_host_pkg::OP_BLANK;
  wire logic end_susp = op_end && op_reg == flash_host_pkg::OP_SUSPEND;
  wire logic end_res = op_end && op_reg == flash_host_pkg::OP_RESUME;
  wire logic jobs_over = finished || poll_fail || hw_start;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_reg <= 1'b0;
      window_reg <= 1'b0;
      prog_run_reg <= 1'b0;
      prog_susp_reg <= 1'b0;
      sect_run_reg <= 1'b0;
      sect_susp_reg <= 1'b0;
      chip_run_reg <= 1'b0;
      blank_run_reg <= 1'b0;
      first_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      if (step_end && !seq_write) begin
        first_reg <= cyc_rdata;
        rdata_reg <= cyc_rdata;
      end
      if (op_end && is_poll) timer_reg <= poll_timer;
      // window shuts on timer high, suspend, or any job end
      window_reg <= end_sect || (window_reg && !(jobs_over || end_susp
        || (op_end && is_poll && poll_timer)));
      prog_run_reg <= (end_prog || (end_res && prog_susp_reg))
        || (prog_run_reg && !(jobs_over || end_susp));
      prog_susp_reg <= (end_susp && prog_run_reg)
        || (prog_susp_reg && !(end_res || hw_start));
      sect_run_reg <= (end_sect || (end_res && !prog_susp_reg))
        || (sect_run_reg && !(jobs_over
        || (end_susp && !prog_run_reg)));
      sect_susp_reg <= (end_susp && !prog_run_reg)
        || (sect_susp_reg && !((end_res && !prog_susp_reg)
        || hw_start));
      chip_run_reg <= end_chip
        || (chip_run_reg && !jobs_over);
      blank_run_reg <= end_blank
        || (blank_run_reg && !jobs_over);
    end
  end
endmodule

// file: verilog/flash_host_pkg.sv
package flash_host_pkg;
  // ===========================================================
  // widths and clock
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  // ===========================================================
  // flash bus timing, plain defaults (least times round up)
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_READ_ACCESS_NS = 100;
  localparam int T_CYCLE_HOLD_NS = 30;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_RECOVER_NS = 20000;
  localparam int CYC_SETUP = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_WE = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_ACCESS = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_HOLD = (T_CYCLE_HOLD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_RST_PULSE = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_RST_RECOVER = (T_RESET_RECOVER_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ===========================================================
  // command addresses and codes written to the device
  localparam logic [22:0] UNLOCK_ADDR_1 = 23'h000555;
  localparam logic [22:0] UNLOCK_ADDR_2 = 23'h0002AA;
  localparam logic [15:0] CODE_UNLOCK_1 = 16'h00AA;
  localparam logic [15:0] CODE_UNLOCK_2 = 16'h0055;
  localparam logic [15:0] CODE_PROGRAM = 16'h00A0;
  localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CODE_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CODE_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CODE_SUSPEND = 16'h00B0;
  localparam logic [15:0] CODE_RESUME = 16'h0030;
  localparam logic [15:0] CODE_READ_RESET = 16'h00F0;
  localparam logic [15:0] CODE_BLANK_SETUP_1 = 16'h00EB;
  localparam logic [15:0] CODE_BLANK_SETUP_2 = 16'h0076;
  localparam logic [15:0] CODE_BLANK_CONFIRM = 16'h0029;
  // ===========================================================
  // device status word bit positions
  localparam int BIT_DATA_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_ERROR = 5;
  localparam int BIT_ERASE_TIMER = 3;
  // ===========================================================
  // own register map and status fields
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_RDATA = 12'h010;
  localparam logic [22:0] ADDR_RESET = 23'h000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_ERASE_CUT = 4;
  localparam int ST_TIMER = 5;
  localparam int ST_WINDOW = 6;
  localparam int ST_PROG_RUN = 7;
  localparam int ST_PROG_SUSP = 8;
  localparam int ST_SECT_RUN = 9;
  localparam int ST_SECT_SUSP = 10;
  localparam int ST_CHIP_RUN = 11;
  localparam int ST_BLANK_RUN = 12;
  // ===========================================================
  // operations software can order
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROGRAM = 4'h1, OP_CHIP = 4'h2,
    OP_SECTOR = 4'h3, OP_ADD = 4'h4, OP_SUSPEND = 4'h5,
    OP_RESUME = 4'h6, OP_BLANK = 4'h7, OP_RESET = 4'h8,
    OP_POLL = 4'h9, OP_HWRESET = 4'hA
  } op_type;
endpackage

// file: verilog/flash_status_judge.sv
`timescale 1ns/1ps
// ===========================================================
// judges two back to back status reads
module flash_status_judge (
  // status words
  input wire logic [15:0] i_first,
  input wire logic [15:0] i_second,
  // verdict
  output logic o_done,
  output logic o_error,
  output logic o_timer
);
  // a still toggle bit means the embedded job has ended
  assign o_done = i_first[flash_host_pkg::BIT_TOGGLE]
    == i_second[flash_host_pkg::BIT_TOGGLE];
  assign o_error = !o_done && i_second[flash_host_pkg::BIT_ERROR];
  assign o_timer = i_second[flash_host_pkg::BIT_ERASE_TIMER];
endmodule
